// ===== core/motor_comp_pkg.sv
package motor_comp_pkg;
    // Register word indexes; the byte address is four times the index
    localparam logic [7:0] IDX_CUTOUT = 8'h0A;
    localparam logic [7:0] IDX_KP = 8'hD1;
    localparam logic [7:0] IDX_KI = 8'hD2;
    localparam logic [7:0] IDX_INTENSITY = 8'hD4;
    localparam logic [7:0] IDX_VREF = 8'hD8;
    localparam logic [7:0] IDX_THROTTLE = 8'hE0;
    localparam logic [7:0] IDX_STATUS = 8'hE1;
    localparam logic [7:0] IDX_SPEED = 8'hE2;
    // Reset values
    localparam logic [7:0] RST_CUTOUT = 8'h00;
    localparam logic [7:0] RST_KP = 8'h19;
    localparam logic [7:0] RST_KI = 8'h14;
    localparam logic [7:0] RST_INTENSITY = 8'hFF;
    localparam logic [7:0] RST_VREF = 8'hA0;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_HZ = 22_000;
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
    localparam int CUTOUT_PARTIAL = 128;
    localparam int TOP_STEP = 127;

    // Loop settings bundle carried to the loop update
    typedef struct packed {
        logic [7:0] kp;
        logic [7:0] ki;
        logic [7:0] cutout;
        logic [7:0] intensity;
        logic [7:0] vref;
    } loop_cfg_t;
endpackage : motor_comp_pkg

// ===== core/comp_factor.sv
`timescale 1ns/1ns
// Registered compensation factor over speed step, 0..255
module comp_factor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] cutout_i,
    input wire logic [7:0] intensity_i,
    input wire logic [6:0] step_i,
    output logic [7:0] factor_o
);
    logic [7:0] factor_next;
    logic [15:0] num;
    logic [7:0] min_lvl;
    logic [15:0] drop;
    logic [7:0] span;

    // Linear drop to zero at cutout step, or to a floor at the top step
    always_comb
    begin
        num = 16'h0000;
        drop = 16'h0000;
        span = 8'h00;
        min_lvl = 8'h00;
        factor_next = intensity_i;
        if (cutout_i == 8'h00)
        begin
            factor_next = intensity_i;
        end
        else if (!cutout_i[7])
        begin
            if ({1'b0, step_i} >= cutout_i)
            begin
                factor_next = 8'h00;
            end
            else
            begin
                num = 16'(intensity_i) * 16'({1'b0, step_i});
                factor_next = 8'(16'(intensity_i) - num / 16'(cutout_i));
            end
        end
        else
        begin
            // Floor scales with cutout minus 128, 0..127 of 127
            span = 8'(cutout_i - 8'h80);
            min_lvl = 8'((16'(intensity_i) * 16'(span)) / 16'h007F);
            drop = 16'(8'(intensity_i - min_lvl)) * 16'({1'b0, step_i});
            factor_next = 8'(16'(intensity_i) - drop / 16'h007F);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            factor_o <= 8'h00;
        end
        else
        begin
            factor_o <= factor_next;
        end
    end
endmodule : comp_factor

// ===== core/motor_load_compensation.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module motor_load_compensation #(
    parameter int PWM_CYC = motor_comp_pkg::PWM_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] motor_counter_voltage_i,
    output logic pwm_o
);
    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] cutout_reg;
    logic [7:0] kp_reg;
    logic [7:0] ki_reg;
    logic [7:0] intensity_reg;
    logic [7:0] vref_reg;
    logic [6:0] throttle_reg;
    logic [7:0] duty_reg;
    logic [6:0] speed_reg;
    motor_comp_pkg::loop_cfg_t cfg;

    // Word index decode, byte address is four times index
    wire [9:0] widx = paddr[11:2];
    wire wr_go = psel && penable && pwrite;
    wire rd_go = psel && penable && !pwrite;
    wire hit_cut = widx == {2'b00, motor_comp_pkg::IDX_CUTOUT};
    wire hit_kp = widx == {2'b00, motor_comp_pkg::IDX_KP};
    wire hit_ki = widx == {2'b00, motor_comp_pkg::IDX_KI};
    wire hit_int = widx == {2'b00, motor_comp_pkg::IDX_INTENSITY};
    wire hit_vref = widx == {2'b00, motor_comp_pkg::IDX_VREF};
    wire hit_thr = widx == {2'b00, motor_comp_pkg::IDX_THROTTLE};
    wire hit_sta = widx == {2'b00, motor_comp_pkg::IDX_STATUS};
    wire hit_spd = widx == {2'b00, motor_comp_pkg::IDX_SPEED};
    wire hit_any = hit_cut | hit_kp | hit_ki | hit_int | hit_vref | hit_thr | hit_sta | hit_spd;
    wire [7:0] rd_sel = hit_cut ? cutout_reg :
                        hit_kp ? kp_reg :
                        hit_ki ? ki_reg :
                        hit_int ? intensity_reg :
                        hit_vref ? vref_reg :
                        hit_thr ? {1'b0, throttle_reg} :
                        hit_sta ? duty_reg :
                        hit_spd ? {1'b0, speed_reg} : 8'h00;

    // Config registers with their documented defaults
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cutout_reg <= motor_comp_pkg::RST_CUTOUT;
            kp_reg <= motor_comp_pkg::RST_KP;
            ki_reg <= motor_comp_pkg::RST_KI;
            intensity_reg <= motor_comp_pkg::RST_INTENSITY;
            vref_reg <= motor_comp_pkg::RST_VREF;
            throttle_reg <= 7'h00;
        end
        else if (wr_go)
        begin
            if (hit_cut)
            begin
                cutout_reg <= pwdata[7:0];
            end
            if (hit_kp)
            begin
                kp_reg <= pwdata[7:0];
            end
            if (hit_ki)
            begin
                ki_reg <= pwdata[7:0];
            end
            if (hit_int)
            begin
                intensity_reg <= pwdata[7:0];
            end
            if (hit_vref)
            begin
                vref_reg <= pwdata[7:0];
            end
            if (hit_thr)
            begin
                throttle_reg <= pwdata[6:0];
            end
        end
    end

    // Zero-wait slave; error on unmapped word or write to read-only
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (!hit_any || (pwrite && (hit_sta || hit_spd)));
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_sel} : prdata;
        end
    end

    assign cfg = '{kp: kp_reg, ki: ki_reg, cutout: cutout_reg,
                   intensity: intensity_reg, vref: vref_reg};

    ////////////////////////////////////////////////////////////////////////
    // Counter voltage input sync and speed estimate
    logic [7:0] emf_s1_reg;
    logic [7:0] emf_s2_reg;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            emf_s1_reg <= 8'h00;
            emf_s2_reg <= 8'h00;
        end
        else
        begin
            emf_s1_reg <= motor_counter_voltage_i;
            emf_s2_reg <= emf_s1_reg;
        end
    end

    // Sample is in tenths of a volt; speed = 127 * emf / vref, clipped
    wire [15:0] emf_scaled = 16'(emf_s2_reg) * 16'h007F;
    wire [15:0] vref_div = (cfg.vref == 8'h00) ? 16'h0001 : 16'(cfg.vref);
    wire [15:0] speed_raw = emf_scaled / vref_div;
    wire [6:0] speed_next = (speed_raw > 16'h007F) ? 7'h7F : speed_raw[6:0];

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            speed_reg <= 7'h00;
        end
        else
        begin
            speed_reg <= speed_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compensation curve over speed steps
    logic [7:0] factor;
    comp_factor u_factor (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .cutout_i(cfg.cutout),
        .intensity_i(cfg.intensity),
        .step_i(throttle_reg),
        .factor_o(factor)
    );

    ////////////////////////////////////////////////////////////////////////
    // PWM counter; one loop update per PWM period
    localparam int CW = $clog2(PWM_CYC);
    logic [CW-1:0] pwm_cnt_reg;
    wire pwm_wrap = pwm_cnt_reg == CW'(PWM_CYC - 1);
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pwm_cnt_reg <= '0;
        end
        else
        begin
            pwm_cnt_reg <= pwm_wrap ? '0 : pwm_cnt_reg + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PI loop; signed, 20-bit terms and integrator, 28-bit weighted sums, in units of 1/256 duty
    logic signed [19:0] integ_reg;
    wire signed [8:0] err = $signed({2'b00, throttle_reg}) - $signed({2'b00, speed_reg});
    wire signed [19:0] p_term = 20'(err * $signed({1'b0, cfg.kp}));
    wire signed [19:0] i_next_raw = integ_reg + 20'(err * $signed({1'b0, cfg.ki}));
    // Clamp integrator to stop windup when motor stalls
    wire signed [19:0] i_next = (i_next_raw > 20'sh0FFFF) ? 20'sh0FFFF :
                                (i_next_raw < -20'sh0FFFF) ? -20'sh0FFFF : i_next_raw;
    // Correction is weighted by the curve factor, factor 255 means full
    wire signed [27:0] corr_w = 28'((p_term + integ_reg) * $signed({1'b0, factor})) >>> 16;
    // Open-loop base is throttle mapped to 0..254; loop adds the rest
    wire signed [27:0] base = 28'($signed({2'b00, throttle_reg, 1'b0}));
    wire signed [27:0] duty_sum = base + corr_w;
    wire gains_zero = (cfg.kp == 8'h00) && (cfg.ki == 8'h00);
    wire [7:0] duty_next = gains_zero ? 8'h00 :
                           (duty_sum < 0) ? 8'h00 :
                           (duty_sum > 28'sd255) ? 8'hFF : duty_sum[7:0];

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            integ_reg <= '0;
            duty_reg <= 8'h00;
        end
        else if (pwm_wrap)
        begin
            integ_reg <= gains_zero ? 20'sh0 : i_next;
            duty_reg <= duty_next;
        end
    end

    // Compare duty against scaled counter position
    wire [CW+7:0] cmp_lhs = (CW+8)'(pwm_cnt_reg) * (CW+8)'(256);
    wire [CW+7:0] cmp_rhs = (CW+8)'(duty_reg) * (CW+8)'(PWM_CYC);
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pwm_o <= 1'b0;
        end
        else
        begin
            pwm_o <= cmp_lhs < cmp_rhs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    // Drive timing: the period depends on the counter alone
    a_pwm_period: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwm_wrap |=> pwm_cnt_reg == '0)
        else $error("pwm period wrong");

    a_cnt_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwm_cnt_reg <= CW'(PWM_CYC - 1))
        else $error("pwm counter past period end");

    a_zero_gain_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gains_zero && pwm_wrap |=> duty_reg == 8'h00)
        else $error("duty not zero with zero gains");

    a_zero_gain_integ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gains_zero && pwm_wrap |=> integ_reg == '0)
        else $error("integrator kept with zero gains");

    a_zero_duty_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        duty_reg == 8'h00 && $stable(duty_reg) |=> !pwm_o)
        else $error("pwm high at zero duty");

    a_duty_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !pwm_wrap |=> $stable(duty_reg))
        else $error("duty moved inside a period");

    a_integ_clamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        integ_reg <= 20'sh0FFFF && integ_reg >= -20'sh0FFFF)
        else $error("integrator out of range");

    // With no weighting and a nonzero gain the drive is the plain throttle map
    a_open_loop_base: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        factor == 8'h00 && !gains_zero && pwm_wrap |=> duty_reg == {$past(throttle_reg), 1'b0})
        else $error("open loop duty wrong");

    // Curve shape, speed estimate and gain defaults
    a_cut_zero_flat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg.cutout == 8'h00 && $stable(cfg.intensity) |=> factor == $past(cfg.intensity))
        else $error("factor not flat");

    a_cut_step_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg.cutout != 8'h00 && !cfg.cutout[7] && {1'b0, throttle_reg} >= cfg.cutout
        |=> factor == 8'h00)
        else $error("factor not zero past cutout");

    a_int_zero_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg.intensity == 8'h00 |=> factor == 8'h00)
        else $error("factor not zero at zero intensity");

    a_factor_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> factor <= $past(intensity_reg))
        else $error("factor above intensity");

    a_partial_floor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg.cutout == 8'hFF && throttle_reg == 7'h7F |=> factor == $past(cfg.intensity))
        else $error("floor wrong");

    a_speed_scale: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg.vref == 8'hA0 && emf_s2_reg == 8'hA0 |=> speed_reg == 7'h7F)
        else $error("speed scale wrong");

    a_speed_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        emf_s2_reg == 8'h00 |=> speed_reg == 7'h00)
        else $error("speed not zero at rest");

    a_gain_reset: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> kp_reg == 8'h19 && ki_reg == 8'h14)
        else $error("gain defaults wrong");

    // Register bus answers
    a_ready_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pready |=> !pready)
        else $error("ready held too long");

    a_err_with_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pslverr |-> pready)
        else $error("error without ready");

    a_rdata_moves: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $changed(prdata) |-> pready)
        else $error("read data moved outside an answer");

    a_unmapped_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        psel && !penable && !hit_any |=> pslverr)
        else $error("unmapped word not refused");

    a_ro_write_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        psel && !penable && pwrite && (hit_sta || hit_spd) |=> pslverr)
        else $error("read only write not refused");

    a_kp_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_go && hit_kp |=> kp_reg == $past(pwdata[7:0]))
        else $error("proportional gain write lost");

    a_ki_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_go && hit_ki |=> ki_reg == $past(pwdata[7:0]))
        else $error("integral gain write lost");

    a_cut_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_go && hit_cut |=> cutout_reg == $past(pwdata[7:0]))
        else $error("cutout write lost");

    a_thr_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_go && hit_thr |=> throttle_reg == $past(pwdata[6:0]))
        else $error("throttle write lost");

    c_pwm_on: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(pwm_o));
    c_zero_gain: cover property (@(posedge clk_i) disable iff (sys_rst_i) gains_zero && pwm_wrap);
    c_cutout: cover property (@(posedge clk_i) disable iff (sys_rst_i) cfg.cutout[7]);
    c_write: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_go && hit_kp);
endmodule : motor_load_compensation

// ===== verification/motor_model.sv
`timescale 1ns/1ns
// Motor whose counter voltage follows the averaged drive, less a load
module motor_model #(
    parameter int PER = 200
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic drive_i,
    input wire logic [7:0] load_i,
    output logic [7:0] emf_o
);
    int cnt_reg;
    int hi_reg;
    int tgt;
    ////////////////////////////////////////////////////////////////////////
    // Load drags speed down; clipped at standstill
    always_comb
    begin
        tgt = hi_reg * 255 / PER - int'(load_i);
        if (tgt < 0)
            tgt = 0;
    end
    // Inertia: move halfway to target once per period, so loop sees a lag
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_reg <= 0;
            hi_reg <= 0;
            emf_o <= 8'h00;
        end
        else if (cnt_reg == PER - 1)
        begin
            cnt_reg <= 0;
            hi_reg <= 0;
            emf_o <= 8'((int'(emf_o) + tgt) / 2);
        end
        else
        begin
            cnt_reg <= cnt_reg + 1;
            hi_reg <= hi_reg + int'(drive_i);
        end
    end
endmodule : motor_model

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam int PER = 200;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] load = 8'h00;
    logic [7:0] emf;
    logic pwm_o;
    logic [31:0] seed = 32'h00004E5B;
    logic [33:0] expq[$];
    int err_count = 0;
    int compares = 0;
    int hi_a, hi_b, gap, rises;
    ////////////////////////////////////////////////////////////////////////
    always #5 clk_i = ~clk_i;
    motor_load_compensation #(.PWM_CYC(PER)) motor_load_compensation_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .motor_counter_voltage_i(emf),
        .pwm_o(pwm_o));
    motor_model #(.PER(PER)) motor_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .drive_i(pwm_o), .load_i(load), .emf_o(emf));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [11:0] ad(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ad
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // One APB transfer; the expectation is noted before the answer can come
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic [31:0] e, logic er);
        int n;
        expq.push_back({w, er, e});
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb
    // Drive samples over a window: high count, rises, spacing of last two rises
    task automatic window(int cyc);
        logic p;
        int last;
        hi_a = 0;
        rises = 0;
        gap = 0;
        last = -1;
        p = 1'b1;
        for (int i = 0; i < cyc; i++)
        begin
            @(posedge clk_i);
            if (pwm_o === 1'b1)
                hi_a++;
            if (pwm_o === 1'b1 && p !== 1'b1)
            begin
                if (last >= 0)
                    gap = i - last;
                last = i;
                rises++;
            end
            p = pwm_o;
        end
    endtask : window
    ////////////////////////////////////////////////////////////////////////
    // Answer watcher: each completed transfer retires the oldest note
    always @(posedge clk_i)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (expq.size() == 0)
                check("unexpected answer", 32'h0, 32'h1);
            else
            begin
                check("pslverr", {31'h0, expq[0][32]}, {31'h0, pslverr});
                if (!expq[0][33] && !expq[0][32])
                    check("prdata", expq[0][31:0], prdata);
                void'(expq.pop_front());
            end
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Reset values, an unmapped word, a write to a read-only word
        apb(ad(motor_comp_pkg::IDX_CUTOUT), 0, 0, 32'h00000000, 0);
        apb(ad(motor_comp_pkg::IDX_KP), 0, 0, 32'h00000019, 0);
        apb(ad(motor_comp_pkg::IDX_KI), 0, 0, 32'h00000014, 0);
        apb(ad(motor_comp_pkg::IDX_INTENSITY), 0, 0, 32'h000000FF, 0);
        apb(ad(motor_comp_pkg::IDX_VREF), 0, 0, 32'h000000A0, 0);
        apb(ad(8'h3F), 0, 0, 32'h0, 1);
        apb(ad(motor_comp_pkg::IDX_STATUS), 1, 32'h000000AA, 32'h0, 1);
        $display("test 1 done");
        // Random settings written back to back and read again
        hi_b = int'(xs() & 32'hFF);
        apb(ad(motor_comp_pkg::IDX_KP), 1, hi_b, 0, 0);
        apb(ad(motor_comp_pkg::IDX_KP), 0, 0, hi_b, 0);
        hi_b = int'(xs() & 32'hFF);
        apb(ad(motor_comp_pkg::IDX_CUTOUT), 1, hi_b, 0, 0);
        apb(ad(motor_comp_pkg::IDX_CUTOUT), 0, 0, hi_b, 0);
        $display("test 2 done");
        // No compensation: drive ignores load, period fixed
        apb(ad(motor_comp_pkg::IDX_CUTOUT), 1, 32'h0, 0, 0);
        apb(ad(motor_comp_pkg::IDX_KP), 1, 32'h19, 0, 0);
        apb(ad(motor_comp_pkg::IDX_INTENSITY), 1, 32'h0, 0, 0);
        apb(ad(motor_comp_pkg::IDX_THROTTLE), 1, 32'h28, 0, 0);
        apb(ad(motor_comp_pkg::IDX_THROTTLE), 0, 0, 32'h28, 0);
        window(20 * PER);
        window(3 * PER);
        hi_b = hi_a;
        check("pwm period", PER, gap);
        load <= 8'(40 + (xs() % 60));
        window(20 * PER);
        window(3 * PER);
        check("drive without compensation", hi_b, hi_a);
        $display("test 3 done");
        // Full compensation: heavier load must raise the drive
        apb(ad(motor_comp_pkg::IDX_INTENSITY), 1, 32'hFF, 0, 0);
        load <= 8'h00;
        window(30 * PER);
        window(3 * PER);
        hi_b = hi_a;
        load <= 8'h30;
        apb(ad(motor_comp_pkg::IDX_KP), 1, 32'hFF, 0, 0);
        window(30 * PER);
        window(3 * PER);
        check("drive rises with load", 1, hi_a > hi_b);
        check("pwm period after gain change", PER, gap);
        $display("test 4 done");
        // Both gains zero stops the motor
        apb(ad(motor_comp_pkg::IDX_KP), 1, 32'h0, 0, 0);
        apb(ad(motor_comp_pkg::IDX_KI), 1, 32'h0, 0, 0);
        window(3 * PER);
        window(2 * PER);
        check("drive with zero gains", 0, hi_a);
        apb(ad(motor_comp_pkg::IDX_STATUS), 0, 0, 32'h0, 0);
        $display("test 5 done");
        tally_and_finish();
    end
endmodule : testbench
